// ==== hdl/ccp_unit.sv ====
// Purpose: Capture, compare and enhanced PWM unit with APB registers.
// Assumes: pclk 100 MHz; pins arrive asynchronously; sleep is synchronous.
// Notes: The timebase is built in; pready is always high.
`timescale 1ns/10ps
`include "ccp_defines.svh"
// What this block does
// - Selection change may raise a false flag.
// - Prescaler cleared when off, non-capture, reset.
// - Prescaler switch keeps count, may fire.
// - Instruction-clocked timebase holds during sleep.
// - Timebase resumes from held value after wake.
// - External clock keeps capture alive in sleep.
// - Compare matches suppressed during sleep.
// - PWM on four pins, 10-bit duty.
// - Output mode selects one of four.
// - Mode field low bits set polarity.
// - Zero control register releases all pins.
// - Outputs wait for first full period.
// - Capture copies timebase, sets flag, overwrites.
// - Fall, rise, 4th or 16th rise.
module ccp_unit
  import ccp_pkg::*;
#(
  parameter int TB_W = 16
)
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and system state.
  input wire logic capture_pin,
  input wire logic tb_clk_pin,
  input wire logic sleep,
  // PWM pins and interrupt.
  output ccp_pins_t pwm_out,
  output ccp_pins_t pwm_oe,
  output logic irq
);
  // Software registers.
  logic [7:0] unit_control_reg;
  logic [7:0] capture_value_lo;
  logic [7:0] capture_value_hi;
  logic [1:0] status;
  logic [1:0] mask;
  logic [7:0] tb_ctrl;
  logic [7:0] period;
  // Timebase state.
  logic [TB_W-1:0] timebase_counter;
  logic [1:0] insn_div;
  logic tb_tick;
  // Pin synchronisers, three stages each.
  logic [2:0] cap_sync;
  logic [2:0] ext_sync;
  logic cap_level;
  logic ext_level;
  // Decoded control fields.
  logic [3:0] event_mode_select;
  ccp_omode_t pwm_output_mode;
  logic cap_mode;
  logic cmp_mode;
  logic pwm_mode;
  // Bus strobes.
  logic wr_en;
  logic rd_setup;
  logic mapped;
  // Events.
  logic cap_fire;
  logic cmp_hit;
  logic spur;
  logic tb_ovf;
  // PWM state.
  logic [9:0] pwm_cnt;
  logic pwm_started;
  logic pwm_raw;
  logic [9:0] duty;
  ccp_pins_t pins_act;
  ccp_pins_t pins_use;

  // Address check shared by read and write paths.
  function automatic logic ccp_hit(input logic [11:0] a);
    ccp_hit = (a == `CCP_OFF_CTRL) || (a == `CCP_OFF_CAP_LO) || (a == `CCP_OFF_CAP_HI) ||
              (a == `CCP_OFF_STAT) || (a == `CCP_OFF_MASK) || (a == `CCP_OFF_TBCTL) ||
              (a == `CCP_OFF_TBVAL) || (a == `CCP_OFF_PERIOD);
  endfunction

  assign event_mode_select = unit_control_reg[`CCP_CTRL_EMODE];
  assign pwm_output_mode = ccp_omode_t'(unit_control_reg[`CCP_CTRL_OMODE]);
  assign cap_mode = event_mode_select[3:2] == 2'b01;
  assign cmp_mode = event_mode_select[3:2] == 2'b10;
  assign pwm_mode = event_mode_select[3:2] == 2'b11;

  // Zero-wait slave; errors only on unmapped addresses.
  assign mapped = ccp_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // Read data is captured in the setup cycle so it is a flop in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      if (paddr == `CCP_OFF_CTRL) begin
        prdata <= {24'h0, unit_control_reg};
      end else if (paddr == `CCP_OFF_CAP_LO) begin
        prdata <= {24'h0, capture_value_lo};
      end else if (paddr == `CCP_OFF_CAP_HI) begin
        prdata <= {24'h0, capture_value_hi};
      end else if (paddr == `CCP_OFF_STAT) begin
        prdata <= {30'h0, status};
      end else if (paddr == `CCP_OFF_MASK) begin
        prdata <= {30'h0, mask};
      end else if (paddr == `CCP_OFF_TBCTL) begin
        prdata <= {24'h0, tb_ctrl};
      end else if (paddr == `CCP_OFF_TBVAL) begin
        prdata <= 32'(timebase_counter);
      end else if (paddr == `CCP_OFF_PERIOD) begin
        prdata <= {24'h0, period};
      end else begin
        // Unmapped reads return zero.
        prdata <= 32'h0;
      end
    end
  end

  // Plain control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_control_reg <= `CCP_CTRL_RST;
      mask <= 2'h0;
      tb_ctrl <= `CCP_TBCTL_RST;
      period <= `CCP_PERIOD_RST;
    end else if (wr_en) begin
      if (paddr == `CCP_OFF_CTRL) begin
        unit_control_reg <= pwdata[7:0];
      end else if (paddr == `CCP_OFF_MASK) begin
        mask <= pwdata[1:0];
      end else if (paddr == `CCP_OFF_TBCTL) begin
        tb_ctrl <= pwdata[7:0];
      end else if (paddr == `CCP_OFF_PERIOD) begin
        period <= pwdata[7:0];
      end
    end
  end

  // Pins pass three flops; only stages two and three are compared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sync <= 3'h0;
      ext_sync <= 3'h0;
      cap_level <= 1'b0;
      ext_level <= 1'b0;
    end else begin
      cap_sync <= {cap_sync[1:0], capture_pin};
      ext_sync <= {ext_sync[1:0], tb_clk_pin};
      if (cap_sync[1] == cap_sync[2]) begin
        cap_level <= cap_sync[2];
      end
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level <= ext_sync[2];
      end
    end
  end

  // Agreed levels that differ from the held level are edges.
  logic cap_rise;
  logic cap_fall;
  logic ext_rise;
  assign cap_rise = (cap_sync[1] == cap_sync[2]) && cap_sync[2] && !cap_level;
  assign cap_fall = (cap_sync[1] == cap_sync[2]) && !cap_sync[2] && cap_level;
  assign ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_div <= 2'h0;
    end else begin
      insn_div <= (insn_div == `CCP_INSN_DIV) ? 2'h0 : insn_div + 2'h1;
    end
  end

  assign tb_tick = tb_ctrl[`CCP_TB_RUN] &&
                   (tb_ctrl[`CCP_TB_EXT] ? ext_rise : (insn_div == `CCP_INSN_DIV) && !sleep);
  assign tb_ovf = tb_tick && (&timebase_counter);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_counter <= '0;
    end else if (tb_tick) begin
      timebase_counter <= timebase_counter + 1'b1;
    end
  end

  ccp_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!cap_mode),
    .sel(ccp_event_t'(event_mode_select[1:0])),
    .edge_rise(cap_rise),
    .edge_fall(cap_fall),
    .fire(cap_fire)
  );

  // polarity change false flag
  // A write that flips the edge sense while the pin already sits at the
  // new post-edge level reads as an edge, as in the original logic.
  assign spur = wr_en && (paddr == `CCP_OFF_CTRL) && cap_mode && (pwdata[3:2] == 2'b01) &&
                ((pwdata[1:0] == 2'h0) != (event_mode_select[1:0] == 2'h0)) &&
                (cap_level == (pwdata[1:0] != 2'h0));

  assign cmp_hit = cmp_mode && !sleep && tb_tick &&
                   (timebase_counter == {capture_value_hi, capture_value_lo});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_lo <= 8'h00;
      capture_value_hi <= 8'h00;
    end else if (cap_mode && cap_fire) begin
      capture_value_lo <= timebase_counter[7:0];
      capture_value_hi <= timebase_counter[15:8];
    end else if (wr_en && paddr == `CCP_OFF_CAP_LO) begin
      capture_value_lo <= pwdata[7:0];
    end else if (wr_en && paddr == `CCP_OFF_CAP_HI) begin
      capture_value_hi <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 2'h0;
    end else begin
      status[`CCP_ST_CAP] <= (status[`CCP_ST_CAP] &&
                              !(wr_en && paddr == `CCP_OFF_STAT && pwdata[`CCP_ST_CAP])) ||
                             (cap_mode && cap_fire) || cmp_hit || spur;
      status[`CCP_ST_OVF] <= (status[`CCP_ST_OVF] &&
                              !(wr_en && paddr == `CCP_OFF_STAT && pwdata[`CCP_ST_OVF])) || tb_ovf;
    end
  end

  // Level interrupt while any unmasked flag stands.
  assign irq = |(status & mask);

  assign duty = {capture_value_lo, unit_control_reg[`CCP_CTRL_DCLSB]};
  assign pwm_raw = pwm_cnt < duty;

  // Period counter; one period is (period+1)*4 clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt <= 10'h0;
    end else if (!pwm_mode || pwm_cnt == {period, 2'b11}) begin
      pwm_cnt <= 10'h0;
    end else begin
      pwm_cnt <= pwm_cnt + 10'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_started <= 1'b0;
    end else if (!pwm_mode) begin
      pwm_started <= 1'b0;
    end else if (pwm_cnt == {period, 2'b11}) begin
      pwm_started <= 1'b1;
    end
  end

  always_comb begin
    pins_act = '0;
    pins_use = '0;
    case (pwm_output_mode)
      CCP_OM_SINGLE: begin
        if (tb_ctrl[`CCP_TB_STEER]) begin
          // Steering copies the waveform onto each selected pin.
          pins_use = ccp_pins_t'(tb_ctrl[`CCP_TB_SMASK]);
          pins_act = pwm_raw ? pins_use : '0;
        end else begin
          pins_use.a = 1'b1;
          pins_act.a = pwm_raw;
        end
      end
      CCP_OM_HALF: begin
        pins_use.a = 1'b1;
        pins_use.b = 1'b1;
        pins_act.a = pwm_raw;
        pins_act.b = !pwm_raw;
      end
      CCP_OM_FWD: begin
        pins_use = '1;
        pins_act.a = 1'b1;
        pins_act.d = pwm_raw;
      end
      default: begin
        pins_use = '1;
        pins_act.c = 1'b1;
        pins_act.b = pwm_raw;
      end
    endcase
  end

  // polarity and release
  // Bit 1 inverts A and C, bit 0 inverts B and D.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= '0;
      pwm_oe <= '0;
    end else if (unit_control_reg == 8'h00 || !pwm_mode) begin
      pwm_out <= '0;
      pwm_oe <= '0;
    end else begin
      pwm_oe <= pins_use;
      pwm_out.a <= (pwm_started && pins_act.a) ^ event_mode_select[1];
      pwm_out.c <= (pwm_started && pins_act.c) ^ event_mode_select[1];
      pwm_out.b <= (pwm_started && pins_act.b) ^ event_mode_select[0];
      pwm_out.d <= (pwm_started && pins_act.d) ^ event_mode_select[0];
    end
  end

  a_cap_store: assert property (@(posedge pclk) disable iff (!presetn)
    cap_mode && cap_fire |=> {capture_value_hi, capture_value_lo} == $past(timebase_counter) &&
    status[`CCP_ST_CAP]) else $error("capture not stored");
  a_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
    sleep && !tb_ctrl[`CCP_TB_EXT] |=> timebase_counter == $past(timebase_counter))
    else $error("timebase moved in sleep");
  a_sleep_cap: assert property (@(posedge pclk) disable iff (!presetn)
    sleep && cap_mode && cap_fire |=> status[`CCP_ST_CAP]) else $error("sleep capture lost");
  a_cmp_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    sleep |-> !cmp_hit) else $error("compare hit in sleep");
  a_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
    unit_control_reg == 8'h00 |=> pwm_oe == '0) else $error("pins not released");
  a_first_period: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pwm_mode) |-> ##1 (pwm_out.a == event_mode_select[1]) [*2])
    else $error("early pulse");
  a_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && pwm_started && pwm_output_mode == CCP_OM_SINGLE && !tb_ctrl[`CCP_TB_STEER] &&
    $stable(unit_control_reg) |=> pwm_out.a == ($past(pwm_raw) ^ $past(event_mode_select[1])))
    else $error("polarity wrong");
  a_half: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && pwm_started && pwm_output_mode == CCP_OM_HALF && event_mode_select[1:0] == 2'h0 &&
    $stable(unit_control_reg) |=> pwm_out.b == !pwm_out.a) else $error("half bridge");
  a_duty: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && pwm_cnt == duty && duty != 10'h0 |-> $past(pwm_raw)) else $error("duty edge");

  c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap_mode && cap_fire);
  c_compare: cover property (@(posedge pclk) disable iff (!presetn) cmp_hit);
  c_pwm_run: cover property (@(posedge pclk) disable iff (!presetn) $rose(pwm_started));
  c_spur: cover property (@(posedge pclk) disable iff (!presetn) spur);
endmodule // ccp_unit

// ==== hdl/ccp_defines.svh ====
// Purpose: Address map, field positions and reset values of the unit.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH
// Register byte offsets.
`define CCP_OFF_CTRL 12'h000
`define CCP_OFF_CAP_LO 12'h004
`define CCP_OFF_CAP_HI 12'h008
`define CCP_OFF_STAT 12'h00c
`define CCP_OFF_MASK 12'h010
`define CCP_OFF_TBCTL 12'h014
`define CCP_OFF_TBVAL 12'h018
`define CCP_OFF_PERIOD 12'h01c
// Control register fields.
`define CCP_CTRL_OMODE 7:6
`define CCP_CTRL_DCLSB 5:4
`define CCP_CTRL_EMODE 3:0
// Status and mask bits.
`define CCP_ST_CAP 0
`define CCP_ST_OVF 1
// Timebase control bits.
`define CCP_TB_RUN 0
`define CCP_TB_EXT 1
`define CCP_TB_STEER 2
`define CCP_TB_SMASK 7:4
// Reset values.
`define CCP_CTRL_RST 8'h00
`define CCP_TBCTL_RST 8'h00
`define CCP_PERIOD_RST 8'hff
// Instruction clock is the system clock divided by this plus one.
`define CCP_INSN_DIV 2'h3
// Prescaler limits for the every-4th and every-16th modes.
`define CCP_DIV4_LAST 4'h3
`define CCP_DIV16_LAST 4'hf
`endif

// ==== hdl/ccp_pkg.sv ====
// Purpose: Types shared by the unit and its prescaler.
// Assumes: Constants live in ccp_defines.svh.
// Notes: None.
package ccp_pkg;
  // Four output pins carried together.
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ccp_pins_t;
  // Output mode field values.
  typedef enum logic [1:0] {
    CCP_OM_SINGLE,
    CCP_OM_HALF,
    CCP_OM_FWD,
    CCP_OM_REV
  } ccp_omode_t;
  // Event selection prescaler choices.
  typedef enum logic [1:0] {
    CCP_EV_FALL,
    CCP_EV_RISE,
    CCP_EV_RISE4,
    CCP_EV_RISE16
  } ccp_event_t;
endpackage

// ==== hdl/ccp_prescaler.sv ====
// Purpose: Capture event qualifier and prescaler counter.
// Assumes: Edge pulses are one cycle and already synchronised.
// Notes: The count is kept across selection changes on purpose.
`timescale 1ns/10ps
`include "ccp_defines.svh"
module ccp_prescaler
  import ccp_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic clear,
  input ccp_event_t sel,
  // Edges and result.
  input wire logic edge_rise,
  input wire logic edge_fall,
  output logic fire
);
  // Rising edges counted since the last fire.
  logic [3:0] cnt;
  // Last count value for the chosen divider.
  logic [3:0] last;

  // Divider limit; >= so a smaller new limit fires on the next rise.
  always_comb begin
    last = (sel == CCP_EV_RISE4) ? `CCP_DIV4_LAST : `CCP_DIV16_LAST;
    case (sel)
      CCP_EV_FALL: fire = edge_fall;
      CCP_EV_RISE: fire = edge_rise;
      default: fire = edge_rise && (cnt >= last);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
    end else if (clear) begin
      cnt <= 4'h0;
    end else if (edge_rise && (sel == CCP_EV_RISE4 || sel == CCP_EV_RISE16)) begin
      // Wrap after firing, otherwise keep counting.
      cnt <= fire ? 4'h0 : cnt + 4'h1;
    end
  end

  a_pre_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> cnt == 4'h0) else $error("prescaler not cleared");
  a_pre_edge: assert property (@(posedge pclk) disable iff (!presetn)
    sel == CCP_EV_RISE |-> fire == edge_rise) else $error("rising mode mismatch");
endmodule // ccp_prescaler

// ==== dv/ccp_bridge_model.sv ====
// Purpose: Far side of the unit: trigger pin, external clock, bridge pins.
// Assumes: The bench calls the tasks; every change follows a rising edge.
// Notes: A bridge pin that nobody drives is pulled low.
`timescale 1ns/10ps
module ccp_bridge_model
  import ccp_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Pins from the unit and their direction.
  input ccp_pins_t pwm_out,
  input ccp_pins_t pwm_oe,
  input wire logic [3:0] pin_dir,
  // Pins to the unit and bridge levels.
  output logic capture_pin,
  output logic tb_clk_pin,
  output logic [3:0] pin_level
);
  // Both lines idle low; the external clock never runs free.
  initial begin
    capture_pin = 1'b0;
    tb_clk_pin = capture_pin;
  end
  // direction gates pin
  // A pin left as input shows the pull-down, not the waveform.
  assign pin_level = {pwm_out} & {pwm_oe} & pin_dir;
  // Sets the trigger level, then lets the sync stages settle.
  task automatic set_level(input logic v);
    @(posedge pclk);
    capture_pin <= v;
    repeat (6) @(posedge pclk);
  endtask
  // Whole pulses, seven cycles each half, far above the miss limit.
  task automatic pulses(input int n);
    repeat (n) begin
      set_level(1'b1);
      set_level(1'b0);
    end
  endtask
  // external clock source
  // Slow external clock; it stands low again after the burst.
  task automatic ext_ticks(input int n);
    repeat (n) begin
      // Two toggles per tick, so the line is low again after each one.
      repeat (3) @(posedge pclk);
      tb_clk_pin <= !tb_clk_pin;
      repeat (3) @(posedge pclk);
      tb_clk_pin <= !tb_clk_pin;
    end
    repeat (6) @(posedge pclk);
  endtask
endmodule // ccp_bridge_model

// ==== dv/capture_compare_pwm_unit_test.sv ====
// Purpose: Self-checking bench for the capture, compare and PWM unit.
// Assumes: Zero-wait APB slave; far side in ccp_bridge_model.
// Notes: Capture values are checked with the timebase held still.
`timescale 1ns/10ps
`include "ccp_defines.svh"
module capture_compare_pwm_unit_test
  import ccp_pkg::*;
;
  // Clock, reset and APB.
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // Pins and system state.
  logic capture_pin, tb_clk_pin, sleep, irq;
  ccp_pins_t pwm_out, pwm_oe;
  logic [3:0] pin_dir, pin_level;
  // Bench state: last read word and error flag.
  int bad_count, num_checks;
  logic [31:0] rd;
  logic err;
  // Expected enables per output mode, pin a in bit 3.
  // Both full-bridge modes drive all four pins, the inactive pair held low.
  logic [3:0] oe_exp [4] = '{4'h8, 4'hc, 4'hf, 4'hf};

  ccp_unit u_ccp_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin(capture_pin), .tb_clk_pin(tb_clk_pin), .sleep(sleep),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
  ccp_bridge_model u_ccp_bridge_model (.pclk(pclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .pin_dir(pin_dir), .capture_pin(capture_pin), .tb_clk_pin(tb_clk_pin), .pin_level(pin_level));

  // 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts every comparison; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; nothing moves until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Sleep level towards the unit, changed just after an edge.
  task automatic set_sleep(input logic s);
    sleep <= s;
  endtask
  // Pin directions of the bridge side, one bit per output pin.
  task automatic set_dir(input logic [3:0] d);
    pin_dir <= d;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // High cycles of pin a at the unit and at the bridge.
  task automatic count_a(input int n, output int hi, output int pl);
    hi = 0;
    pl = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pwm_out.a === 1'b1) hi++;
      if (pin_level[3] === 1'b1) pl++;
    end
  endtask

  // Reset values, read-only timebase and an unmapped slot.
  task automatic t_reset();
    rdchk(`CCP_OFF_CTRL, `CCP_CTRL_RST);
    rdchk(`CCP_OFF_STAT, 32'h0);
    rdchk(`CCP_OFF_TBCTL, `CCP_TBCTL_RST);
    rdchk(`CCP_OFF_PERIOD, `CCP_PERIOD_RST);
    wr(`CCP_OFF_TBVAL, 32'hab);
    rdchk(`CCP_OFF_TBVAL, 32'h0);
    wr(`CCP_OFF_MASK, 32'h3);
    rdchk(`CCP_OFF_MASK, 32'h3);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("done reset");
  endtask
  // Timebase frozen between external bursts, so values are exact.
  task automatic t_capture();
    logic [15:0] v;
    wr(`CCP_OFF_TBCTL, 32'h3);
    wr(`CCP_OFF_CTRL, 32'h05);
    wr(`CCP_OFF_MASK, 32'h1);
    wr(`CCP_OFF_STAT, 32'h3);
    u_ccp_bridge_model.ext_ticks(7);
    apb(1'b0, `CCP_OFF_TBVAL, 32'h0);
    v = rd[15:0];
    u_ccp_bridge_model.pulses(1);
    rdchk(`CCP_OFF_STAT, 32'h1); // flag set
    chk(irq, 1'b1); // irq raised
    rdchk(`CCP_OFF_CAP_LO, {24'h0, v[7:0]}); // low byte
    rdchk(`CCP_OFF_CAP_HI, {24'h0, v[15:8]}); // high byte
    set_sleep(1'b1);
    u_ccp_bridge_model.ext_ticks(5);
    v = v + 16'h5;
    rdchk(`CCP_OFF_TBVAL, {16'h0, v}); // counts asleep
    u_ccp_bridge_model.pulses(1);
    rdchk(`CCP_OFF_CAP_LO, {24'h0, v[7:0]}); // overwritten
    set_sleep(1'b0);
    wr(`CCP_OFF_STAT, 32'h1);
    rdchk(`CCP_OFF_STAT, 32'h0);
    chk(irq, 1'b0); // irq cleared
    $display("done capture");
  endtask
  // Falling sense ignores the rising edge.
  task automatic t_fall();
    wr(`CCP_OFF_CTRL, 32'h0);
    wr(`CCP_OFF_CTRL, 32'h04);
    wr(`CCP_OFF_STAT, 32'h1);
    u_ccp_bridge_model.set_level(1'b1);
    rdchk(`CCP_OFF_STAT, 32'h0); // rise ignored
    u_ccp_bridge_model.set_level(1'b0);
    rdchk(`CCP_OFF_STAT, 32'h1); // fall taken
    $display("done fall");
  endtask
  // A partial count is dropped by switching the unit off.
  task automatic t_presc(input logic [7:0] m, input int n);
    wr(`CCP_OFF_CTRL, {24'h0, m});
    u_ccp_bridge_model.pulses(n - 1);
    wr(`CCP_OFF_CTRL, 32'h0); // off first
    wr(`CCP_OFF_CTRL, {24'h0, m});
    wr(`CCP_OFF_STAT, 32'h1);
    u_ccp_bridge_model.pulses(n - 1);
    rdchk(`CCP_OFF_STAT, 32'h0); // count cleared
    u_ccp_bridge_model.pulses(1);
    rdchk(`CCP_OFF_STAT, 32'h1); // nth rise
    $display("done prescaler %h", m);
  endtask
  // Mode switches with the interrupt masked, as software should.
  task automatic t_switch();
    wr(`CCP_OFF_MASK, 32'h0); // masked
    wr(`CCP_OFF_CTRL, 32'h04);
    u_ccp_bridge_model.set_level(1'b1);
    wr(`CCP_OFF_STAT, 32'h1);
    wr(`CCP_OFF_CTRL, 32'h05);
    rdchk(`CCP_OFF_STAT, 32'h1); // false flag
    chk(irq, 1'b0); // no interrupt
    wr(`CCP_OFF_STAT, 32'h1); // flag cleared
    u_ccp_bridge_model.set_level(1'b0);
    wr(`CCP_OFF_CTRL, 32'h0);
    wr(`CCP_OFF_CTRL, 32'h07);
    wr(`CCP_OFF_STAT, 32'h1);
    u_ccp_bridge_model.pulses(5);
    wr(`CCP_OFF_CTRL, 32'h06);
    u_ccp_bridge_model.pulses(1);
    rdchk(`CCP_OFF_STAT, 32'h1); // count kept
    $display("done switch");
  endtask
  // Instruction-clocked timebase and compare across sleep.
  task automatic t_sleep();
    logic [15:0] a, b;
    wr(`CCP_OFF_TBCTL, 32'h1);
    repeat (100) @(posedge pclk);
    set_sleep(1'b1);
    apb(1'b0, `CCP_OFF_TBVAL, 32'h0);
    a = rd[15:0];
    wr(`CCP_OFF_CAP_LO, {24'h0, a[7:0] + 8'h3});
    wr(`CCP_OFF_CAP_HI, {24'h0, 8'((a + 16'h3) >> 8)});
    wr(`CCP_OFF_CTRL, 32'h08);
    wr(`CCP_OFF_STAT, 32'h1);
    repeat (60) @(posedge pclk);
    rdchk(`CCP_OFF_STAT, 32'h0); // no match asleep
    rdchk(`CCP_OFF_TBVAL, {16'h0, a}); // held
    set_sleep(1'b0);
    repeat (40) @(posedge pclk);
    apb(1'b0, `CCP_OFF_TBVAL, 32'h0);
    b = rd[15:0] - a;
    chk(b >= 16'h8 && b <= 16'hc, 1'b1); // resumes
    rdchk(`CCP_OFF_STAT, 32'h1); // match awake
    $display("done sleep");
  endtask
  // Period 16 cycles, duty 4 cycles on pin a.
  task automatic t_pwm();
    int k, hi, pl;
    wr(`CCP_OFF_PERIOD, 32'h3);
    wr(`CCP_OFF_CAP_LO, 32'h1);
    wr(`CCP_OFF_CTRL, 32'h0c);
    k = 0;
    while (pwm_out.a !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    k = 0;
    while (pwm_out.a === 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    chk(k, 4); // first pulse whole
    count_a(32, hi, pl);
    chk(hi, 8); // duty
    chk(pl, 8); // reaches pin
    for (int m = 0; m < 4; m++) begin
      wr(`CCP_OFF_CTRL, {24'h0, 2'(m), 6'h0c});
      repeat (2) @(posedge pclk);
      chk(pwm_oe, oe_exp[m]); // pin map
    end
    wr(`CCP_OFF_CTRL, 32'h0e);
    repeat (40) @(posedge pclk);
    count_a(32, hi, pl);
    chk(hi, 24); // inverted
    set_dir(4'h7);
    wr(`CCP_OFF_CTRL, 32'h0c);
    repeat (40) @(posedge pclk);
    count_a(32, hi, pl);
    chk(pl, 0); // pin left input
    set_dir(4'hf);
    wr(`CCP_OFF_TBCTL, 32'hf5);
    repeat (2) @(posedge pclk);
    chk(pwm_oe, 4'hf); // steering
    wr(`CCP_OFF_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk(pwm_oe, 4'h0); // pins released
    chk(pin_level, 4'h0); // pull-down seen
    $display("done pwm");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Ceiling well above the fewer than two thousand cycles the tests take.
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    end_sim();
  end

  // Main sequence.
  initial begin
    bad_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    // Address, write and data stay unset until the first transfer;
    // with psel low the unit never looks at them.
    {psel, penable} = 2'h0;
    set_sleep(1'b0);
    set_dir(4'hf);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_capture();
    t_fall();
    t_presc(8'h05, 1);
    t_presc(8'h06, 4);
    t_presc(8'h07, 16);
    t_switch();
    t_sleep();
    t_pwm();
    end_sim();
  end
endmodule // capture_compare_pwm_unit_test
